// >>> design/ppm_pkg.sv
// Package: register map, field positions, reset values, timing and state types for the power-mode block
package ppm_pkg;

  // ****************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************
  localparam logic [5:0] REG_BASIC_CTRL = 6'h00;
  localparam logic [5:0] REG_DIG_CTRL = 6'h10;
  localparam logic [5:0] REG_AFE_CTRL = 6'h11;
  localparam logic [5:0] REG_EXP_CTRL = 6'h18;
  localparam logic [5:0] REG_PHY_CTRL2 = 6'h1F;
  localparam logic [5:0] REG_PWR_STATUS = 6'h20;
  localparam logic [5:0] REG_PWR_CFG = 6'h21;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_AUTONEG_EN = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_PLL_AUTO_OFF = 4;
  localparam int BIT_SLOW_OSC = 5;
  localparam int BIT_ENERGY_DETECT_POWER_DOWN_DISABLE = 11;
  localparam int BIT_PWR_SAVE = 10;
  localparam int BIT_LONG_PULSE = 0;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic RST_AUTONEG_EN = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_PLL_AUTO_OFF = 1'b0;
  localparam logic RST_SLOW_OSC = 1'b0;
  localparam logic RST_ENERGY_DETECT_POWER_DOWN_DISABLE = 1'b1;
  localparam logic RST_PWR_SAVE = 1'b0;
  localparam logic RST_LONG_PULSE = 1'b0;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_FREQ_MHZ = 125;
  localparam int LINK_PULSE_US = 16000;
  localparam int LINK_PULSE_CYC = LINK_PULSE_US * CLK_FREQ_MHZ;
  localparam int WAKE_HOLD_US = 2000;
  localparam int WAKE_HOLD_CYC = WAKE_HOLD_US * CLK_FREQ_MHZ;
  localparam int LONG_PULSE_SHIFT = 2;
  localparam int CNT_W = 26;

  // ****************************************************
  // State types
  // ****************************************************
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_PSAVE,
    ST_ENERGY_DETECT_POWER_DOWN,
    ST_WAKE,
    ST_PDOWN
  } ppm_state_t;

  typedef struct packed {
    ppm_state_t st;
    logic an_en;
    logic pd;
    logic pll_auto;
    logic slow_osc;
    logic energy_detect_power_down_dis;
    logic ps_en;
    logic long_pulse;
    logic link_s1;
    logic link_s2;
    logic nrg_s1;
    logic nrg_s2;
    logic [CNT_W-1:0] pulse_cnt;
    logic [CNT_W-1:0] wake_cnt;
    logic link_pulse;
    logic soft_rst;
    logic [31:0] prdata;
  } ppm_regs_t;

endpackage

// >>> design/ppm_power_mode_ctrl.sv
// Power-mode sequencer of a 10/100 transceiver with an APB register slave
//
// Overview of operation
// - A one in the power-saving enable bit enables power-saving, active only with auto-negotiation on and no link.
// - In power-saving every transceiver block except transmitter, energy detector and PLL is off.
// - Power-saving enable comes up disabled after reset.
// - A zero in the energy-detect power-down disable bit enables it, active only with auto-negotiation on and no link.
// - With PLL auto-off set, energy-detect power-down also turns the PLL off, leaving transmitter and detector.
// - In energy-detect power-down link pulses keep going out periodically, optionally at a longer interval.
// - Energy-detect power-down comes up disabled after reset.
// - A one in the power-down bit disables everything but the management interface.
// - Writing the power-down bit back to zero leaves power-down.
// - A one in the slow-oscillator bit disconnects the reference clock input and selects the slow oscillator.
// - Slow oscillator together with power-down is the lowest power state, management alone working.
// - The auto-negotiation enable bit gates both cable-unplugged low-power modes.
`timescale 1ns/1ps

module ppm_power_mode_ctrl
  import ppm_pkg::*;
#(
  parameter int unsigned PULSE_CYC = LINK_PULSE_CYC,
  parameter int unsigned WAKE_CYC = WAKE_HOLD_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic link_up_i,
  input wire logic energy_detect_i,
  output logic xcvr_core_pwr_o,
  output logic tx_pwr_o,
  output logic energy_det_pwr_o,
  output logic pll_pwr_o,
  output logic link_pulse_o,
  output logic slow_osc_sel_o,
  output logic reference_clock_input_en_o,
  output logic soft_reset_o
);

  // ****************************************************
  // Constants sized to their targets
  // ****************************************************
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'((PULSE_CYC << LONG_PULSE_SHIFT) - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  ppm_regs_t cur;
  ppm_regs_t next_cur;
  logic acc;
  logic wr;
  logic setup;
  logic [5:0] idx;
  logic mapped;
  logic lp_ok;
  logic [31:0] rd_val;

  // ****************************************************
  // APB decode
  // ****************************************************
  // Zero-wait slave; read data is captured in the setup cycle
  assign idx = paddr_i[7:2];
  assign mapped = (paddr_i[1:0] == 2'h0) &&
                  (idx == REG_BASIC_CTRL || idx == REG_DIG_CTRL || idx == REG_AFE_CTRL ||
                   idx == REG_EXP_CTRL || idx == REG_PHY_CTRL2 || idx == REG_PWR_STATUS ||
                   idx == REG_PWR_CFG);
  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i && mapped;
  assign pready_o = 1'b1;
  // Error only in the access phase, so an idle bus never flags one
  assign pslverr_o = acc && !mapped;
  assign prdata_o = cur.prdata;

  // Read mux; soft reset self-clears so it always reads zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (idx)
      REG_BASIC_CTRL: begin
        rd_val[BIT_AUTONEG_EN] = cur.an_en;
        rd_val[BIT_POWER_DOWN] = cur.pd;
      end
      REG_DIG_CTRL: rd_val[BIT_PLL_AUTO_OFF] = cur.pll_auto;
      REG_AFE_CTRL: rd_val[BIT_SLOW_OSC] = cur.slow_osc;
      REG_EXP_CTRL: rd_val[BIT_ENERGY_DETECT_POWER_DOWN_DISABLE] = cur.energy_detect_power_down_dis;
      REG_PHY_CTRL2: rd_val[BIT_PWR_SAVE] = cur.ps_en;
      REG_PWR_STATUS: rd_val = {24'h00_0000, cur.pd && cur.slow_osc, cur.nrg_s2, cur.link_s2, pll_pwr_o,
                                cur.st == ST_WAKE, cur.st == ST_PDOWN, cur.st == ST_ENERGY_DETECT_POWER_DOWN,
                                cur.st == ST_PSAVE};
      REG_PWR_CFG: rd_val[BIT_LONG_PULSE] = cur.long_pulse;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ****************************************************
  // Next-state logic
  // ****************************************************
  // low-power modes need auto-negotiation on and no link
  assign lp_ok = cur.an_en && !cur.link_s2;

  always_comb begin
    next_cur = cur;
    next_cur.soft_rst = 1'b0;
    next_cur.link_pulse = 1'b0;
    // Two-flop synchronisers for the pin inputs
    next_cur.link_s1 = link_up_i;
    next_cur.link_s2 = cur.link_s1;
    next_cur.nrg_s1 = energy_detect_i;
    next_cur.nrg_s2 = cur.nrg_s1;
    if (setup) begin
      next_cur.prdata = rd_val;
    end

    // Register writes
    if (wr) begin
      unique case (idx)
        REG_BASIC_CTRL: begin
          next_cur.an_en = pwdata_i[BIT_AUTONEG_EN];
          next_cur.pd = pwdata_i[BIT_POWER_DOWN];
        end
        REG_DIG_CTRL: next_cur.pll_auto = pwdata_i[BIT_PLL_AUTO_OFF];
        REG_AFE_CTRL: next_cur.slow_osc = pwdata_i[BIT_SLOW_OSC];
        REG_EXP_CTRL: next_cur.energy_detect_power_down_dis = pwdata_i[BIT_ENERGY_DETECT_POWER_DOWN_DISABLE];
        REG_PHY_CTRL2: next_cur.ps_en = pwdata_i[BIT_PWR_SAVE];
        REG_PWR_CFG: next_cur.long_pulse = pwdata_i[BIT_LONG_PULSE];
        default: next_cur.prdata = cur.prdata;
      endcase
    end

    // Soft reset returns every control bit to its default, last step of the exit sequence
    if (wr && idx == REG_BASIC_CTRL && pwdata_i[BIT_SOFT_RESET]) begin
      next_cur.soft_rst = 1'b1;
      next_cur.an_en = RST_AUTONEG_EN;
      next_cur.pd = RST_POWER_DOWN;
      next_cur.pll_auto = RST_PLL_AUTO_OFF;
      next_cur.slow_osc = RST_SLOW_OSC;
      next_cur.energy_detect_power_down_dis = RST_ENERGY_DETECT_POWER_DOWN_DISABLE;
      next_cur.ps_en = RST_PWR_SAVE;
      next_cur.long_pulse = RST_LONG_PULSE;
    end

    // Power state machine
    next_cur.pulse_cnt = '0;
    next_cur.wake_cnt = '0;
    unique case (cur.st)
      ST_NORMAL: begin
        // energy-detect power-down wins over power-saving, saving more
        if (lp_ok && !cur.energy_detect_power_down_dis && !cur.nrg_s2) begin
          next_cur.st = ST_ENERGY_DETECT_POWER_DOWN;
        end else if (lp_ok && cur.ps_en && !cur.nrg_s2) begin
          next_cur.st = ST_PSAVE;
        end
      end
      ST_PSAVE: begin
        if (cur.nrg_s2) begin
          next_cur.st = ST_WAKE;
        end else if (!lp_ok || !cur.ps_en || !cur.energy_detect_power_down_dis) begin
          next_cur.st = ST_NORMAL;
        end
      end
      ST_ENERGY_DETECT_POWER_DOWN: begin
        // periodic link pulses, interval optionally lengthened
        next_cur.pulse_cnt = cur.pulse_cnt + CNT_ONE;
        // Compare with >= so a shortened interval cannot strand the count past its end
        if (cur.pulse_cnt >= (cur.long_pulse ? LONG_LAST : PULSE_LAST)) begin
          next_cur.pulse_cnt = '0;
          next_cur.link_pulse = 1'b1;
        end
        if (cur.nrg_s2) begin
          next_cur.st = ST_WAKE;
        end else if (!lp_ok || cur.energy_detect_power_down_dis) begin
          next_cur.st = ST_NORMAL;
        end
      end
      ST_WAKE: begin
        // Hold blocks powered long enough for link establishment to start
        next_cur.wake_cnt = cur.wake_cnt + CNT_ONE;
        if (cur.link_s2 || !cur.an_en || cur.wake_cnt == WAKE_LAST) begin
          next_cur.st = ST_NORMAL;
        end
      end
      ST_PDOWN: begin
        // leave power-down once the bit is cleared
        if (!cur.pd) begin
          next_cur.st = ST_NORMAL;
        end
      end
      default: next_cur.st = ST_NORMAL;
    endcase
    if (cur.pd) begin
      next_cur.st = ST_PDOWN;
      // No link pulse leaves a powered-down transmitter
      next_cur.link_pulse = 1'b0;
      next_cur.pulse_cnt = '0;
      next_cur.wake_cnt = '0;
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur <= '{st: ST_NORMAL, an_en: RST_AUTONEG_EN, pd: RST_POWER_DOWN, pll_auto: RST_PLL_AUTO_OFF,
               slow_osc: RST_SLOW_OSC, energy_detect_power_down_dis: RST_ENERGY_DETECT_POWER_DOWN_DISABLE, ps_en: RST_PWR_SAVE,
               long_pulse: RST_LONG_PULSE, prdata: 32'h0000_0000, pulse_cnt: '0, wake_cnt: '0,
               default: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************
  // Power outputs
  // ****************************************************
  // receive-side blocks only in normal operation or while waking
  assign xcvr_core_pwr_o = (cur.st == ST_NORMAL) || (cur.st == ST_WAKE);
  // power-down leaves only the management slave running
  assign tx_pwr_o = cur.st != ST_PDOWN;
  assign energy_det_pwr_o = cur.st != ST_PDOWN;
  // PLL drops in power-down, and in energy-detect power-down with auto-off set
  assign pll_pwr_o = (cur.st != ST_PDOWN) && !((cur.st == ST_ENERGY_DETECT_POWER_DOWN) && cur.pll_auto);
  assign link_pulse_o = cur.link_pulse;
  // reference input gated off while the slow oscillator runs
  assign slow_osc_sel_o = cur.slow_osc;
  assign reference_clock_input_en_o = !cur.slow_osc;
  assign soft_reset_o = cur.soft_rst;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_psave_entry_cond: assert property (
    (cur.st == ST_PSAVE && $past(cur.st) == ST_NORMAL) |-> $past(cur.ps_en && cur.an_en && !cur.link_s2))
    else $error("power-saving entered without its conditions");
  a_psave_power_map: assert property (
    cur.st == ST_PSAVE |-> !xcvr_core_pwr_o && tx_pwr_o && energy_det_pwr_o && pll_pwr_o)
    else $error("wrong blocks powered in power-saving");
  a_soft_rst_psave: assert property (
    cur.soft_rst |-> !cur.ps_en ##1 cur.st != ST_PSAVE)
    else $error("power-saving not disabled after reset");
  a_energy_detect_power_down_entry_cond: assert property (
    (cur.st == ST_ENERGY_DETECT_POWER_DOWN && $past(cur.st) == ST_NORMAL) |-> $past(!cur.energy_detect_power_down_dis && cur.an_en && !cur.link_s2))
    else $error("energy-detect power-down entered without its conditions");
  a_energy_detect_power_down_pll_off: assert property (
    (cur.st == ST_ENERGY_DETECT_POWER_DOWN && cur.pll_auto) |-> !pll_pwr_o && !xcvr_core_pwr_o && tx_pwr_o && energy_det_pwr_o)
    else $error("PLL not off in energy-detect power-down");
  a_pulse_in_energy_detect_power_down: assert property (
    link_pulse_o |-> $past(cur.st) == ST_ENERGY_DETECT_POWER_DOWN && cur.pulse_cnt == '0)
    else $error("link pulse outside energy-detect power-down");
  a_soft_rst_energy_detect_power_down: assert property (
    cur.soft_rst |-> cur.energy_detect_power_down_dis ##1 cur.st != ST_ENERGY_DETECT_POWER_DOWN)
    else $error("energy-detect power-down not disabled after reset");
  a_pdown_entry: assert property (
    $rose(cur.pd) |=> cur.st == ST_PDOWN && !tx_pwr_o && !pll_pwr_o && !xcvr_core_pwr_o)
    else $error("power-down not entered");
  a_pdown_exit: assert property (
    (cur.st == ST_PDOWN && !cur.pd) |=> cur.st == ST_NORMAL)
    else $error("power-down not left");
  a_slow_osc_write: assert property (
    (wr && idx == REG_AFE_CTRL && !pwdata_i[BIT_SOFT_RESET]) |=>
      slow_osc_sel_o == $past(pwdata_i[BIT_SLOW_OSC]) && reference_clock_input_en_o != slow_osc_sel_o)
    else $error("slow oscillator select not following write");
  a_lowest_power: assert property (
    (cur.st == ST_PDOWN && cur.slow_osc) |-> !tx_pwr_o && !pll_pwr_o && !energy_det_pwr_o && pready_o)
    else $error("functions alive in lowest power state");
  a_autoneg_gate: assert property (
    (!cur.an_en && $past(!cur.an_en)) |-> cur.st != ST_PSAVE && cur.st != ST_ENERGY_DETECT_POWER_DOWN)
    else $error("low-power mode with auto-negotiation off");
  a_energy_wake: assert property (
    ((cur.st == ST_PSAVE || cur.st == ST_ENERGY_DETECT_POWER_DOWN) && cur.nrg_s2 && !cur.pd) |=> cur.st == ST_WAKE && xcvr_core_pwr_o)
    else $error("line energy did not wake the transceiver");

  // ****************************************************
  // Exit paths, pulse timing, defaults and status
  // ****************************************************
  a_pd_overrides: assert property (
    cur.pd |=> cur.st == ST_PDOWN)
    else $error("power-down bit did not override the mode");
  a_pdown_quiet: assert property (
    cur.st == ST_PDOWN |-> !link_pulse_o)
    else $error("link pulse sent while powered down");
  a_mgmt_answers: assert property (
    (psel_i && penable_i) |-> pready_o && (pslverr_o == !mapped))
    else $error("management slave did not answer");
  a_psave_exit: assert property (
    (cur.st == ST_PSAVE && (!lp_ok || !cur.ps_en) && !cur.nrg_s2 && !cur.pd) |=> cur.st == ST_NORMAL)
    else $error("power-saving held after its conditions ended");
  a_link_blocks_lp: assert property (
    (cur.link_s2 && $past(cur.link_s2)) |-> cur.st != ST_PSAVE && cur.st != ST_ENERGY_DETECT_POWER_DOWN)
    else $error("low-power mode held with link present");
  a_energy_detect_power_down_exit: assert property (
    (cur.st == ST_ENERGY_DETECT_POWER_DOWN && (!lp_ok || cur.energy_detect_power_down_dis) && !cur.nrg_s2 && !cur.pd) |=> cur.st == ST_NORMAL)
    else $error("energy-detect power-down held after its conditions ended");
  a_energy_detect_power_down_pll_kept: assert property (
    (cur.st == ST_ENERGY_DETECT_POWER_DOWN && !cur.pll_auto) |-> pll_pwr_o && !xcvr_core_pwr_o && tx_pwr_o && energy_det_pwr_o)
    else $error("wrong blocks powered in energy-detect power-down");
  a_pll_only_energy_detect_power_down: assert property (
    (cur.st != ST_ENERGY_DETECT_POWER_DOWN && cur.st != ST_PDOWN) |-> pll_pwr_o)
    else $error("PLL off outside energy-detect power-down");
  a_pulse_due: assert property (
    (cur.st == ST_ENERGY_DETECT_POWER_DOWN && !cur.pd && cur.pulse_cnt >= (cur.long_pulse ? LONG_LAST : PULSE_LAST)) |=> link_pulse_o)
    else $error("link pulse missing at end of interval");
  a_pulse_single: assert property (
    link_pulse_o |=> !link_pulse_o)
    else $error("link pulse longer than one cycle");
  a_soft_rst_defaults: assert property (
    cur.soft_rst |-> cur.an_en && !cur.pd && !cur.slow_osc && !cur.pll_auto && !cur.long_pulse)
    else $error("control bits not at defaults after soft reset");
  a_wake_exit: assert property (
    (cur.st == ST_WAKE && (cur.link_s2 || cur.wake_cnt == WAKE_LAST) && !cur.pd) |=> cur.st == ST_NORMAL)
    else $error("wake state did not end");
  a_wake_power: assert property (
    cur.st == ST_WAKE |-> xcvr_core_pwr_o && tx_pwr_o && energy_det_pwr_o && pll_pwr_o)
    else $error("blocks not powered while waking");
  a_status_lowest: assert property (
    (setup && idx == REG_PWR_STATUS) |=> prdata_o[7] == $past(cur.pd && cur.slow_osc))
    else $error("lowest power flag wrong in status read");

  // Main scenarios the bench is expected to reach
  c_psave: cover property (cur.st == ST_NORMAL ##1 cur.st == ST_PSAVE);
  c_energy_detect_power_down_pulse: cover property (cur.st == ST_ENERGY_DETECT_POWER_DOWN && link_pulse_o);
  c_lowest: cover property (cur.st == ST_PDOWN && cur.slow_osc);
  c_wake: cover property (cur.st == ST_WAKE ##1 cur.st == ST_NORMAL);
  c_energy_detect_power_down_exit: cover property (cur.st == ST_ENERGY_DETECT_POWER_DOWN ##1 cur.st == ST_NORMAL);

endmodule // ppm_power_mode_ctrl

// >>> tb/ppm_mgmt_model.sv
// Station management model: APB master with the ordered slow-oscillator exit
`timescale 1ns/1ps

module ppm_mgmt_model (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic hang_o
);
  // Idle bus from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
    hang_o = 1'b0;
  end

  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_i);
    end
    if (pready_i !== 1'b1) hang_o <= 1'b1; // Bound used up, flagged to the bench
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask

  // clear slow osc, clear power-down, then soft reset
  task automatic exit_slow_osc();
    logic [31:0] q;
    logic e;
    xfer(1'b1, 8'h44, 32'h0, q, e);
    xfer(1'b1, 8'h00, 32'h00001000, q, e);
    xfer(1'b1, 8'h00, 32'h00009000, q, e);
  endtask
endmodule // ppm_mgmt_model

// >>> tb/test_phy_power_mode_control.sv
// Self-checking bench of the power-mode sequencer
`timescale 1ns/1ps

module test_phy_power_mode_control;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic link_up_i = 1'b0;
  logic energy_detect_i = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, hang;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic core, txp, edp, pll, lpulse, slow, refen, srst;
  int n_errors = 0;
  int tests_run = 0;
  int n_srst = 0;
  logic [15:0] seed = 16'h3D63;

  always #4 ref_clk_i = ~ref_clk_i;

  ppm_mgmt_model mgmt_u (.clk_i(ref_clk_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .hang_o(hang));

  // Small counts keep the run short
  ppm_power_mode_ctrl #(.PULSE_CYC(16), .WAKE_CYC(32)) dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link_up_i(link_up_i),
    .energy_detect_i(energy_detect_i), .xcvr_core_pwr_o(core), .tx_pwr_o(txp), .energy_det_pwr_o(edp),
    .pll_pwr_o(pll), .link_pulse_o(lpulse), .slow_osc_sel_o(slow), .reference_clock_input_en_o(refen),
    .soft_reset_o(srst));

  // Soft reset pulses and bus hangs
  always @(posedge ref_clk_i) begin
    if (srst === 1'b1) n_srst++;
    if (hang === 1'b1) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    mgmt_u.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    mgmt_u.xfer(1'b0, a, 32'h0, q, e);
  endtask

  // Power enables {core, tx, detector, pll}, bounded settle
  task automatic pins(input logic [3:0] exp);
    int n;
    for (n = 0; n < 60 && {core, txp, edp, pll} !== exp; n++) @(posedge ref_clk_i);
    chk_pin("power enables", exp, {core, txp, edp, pll});
    if (n == 60) wrap_up();
  endtask

  task automatic pulses(input int cyc, input int exp);
    int c;
    c = 0;
    repeat (cyc) begin
      @(posedge ref_clk_i);
      #1;
      if (lpulse === 1'b1) c++;
    end
    chk_reg("link pulses", exp, c);
  endtask

  task automatic line(input logic lk, input logic en);
    @(posedge ref_clk_i);
    link_up_i <= lk;
    energy_detect_i <= en;
  endtask

  logic [7:0] addr_t[5] = '{8'h00, 8'h40, 8'h44, 8'h60, 8'h7C};
  logic [31:0] dflt_t[5] = '{32'h1000, 32'h0, 32'h0, 32'h800, 32'h0};
  logic [31:0] q;
  logic e;

  initial begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    // Defaults after reset, then a refused unmapped access
    foreach (addr_t[i]) begin
      rd(addr_t[i], q, e);
      chk_reg("reset value", dflt_t[i], q);
    end
    rd(8'h08, q, e);
    chk_reg("unmapped read", 32'h0, q);
    chk_reg("unmapped slverr", 32'h1, {31'h0, e});
    // Random writes, only the documented field sticks
    repeat (4) begin
      seed = lfsr(seed);
      wr(8'h40, {16'h0, seed});
      rd(8'h40, q, e);
      chk_reg("pll auto field", {27'h0, seed[4], 4'h0}, q);
    end
    wr(8'h40, 32'h0);
    wr(8'h7C, 32'h400);
    pins(4'b0111);
    line(1'b1, 1'b0);
    pins(4'b1111);
    line(1'b0, 1'b0);
    pins(4'b0111);
    line(1'b0, 1'b1);
    pins(4'b1111);
    line(1'b0, 1'b0);
    pins(4'b0111);
    wr(8'h00, 32'h0);
    pins(4'b1111);
    wr(8'h00, 32'h1000);
    pins(4'b0111);
    // Energy-detect power-down with automatic PLL off
    wr(8'h7C, 32'h0);
    wr(8'h40, 32'h10);
    wr(8'h60, 32'h0);
    pins(4'b0110);
    pulses(64, 4);
    wr(8'h84, 32'h1);
    pulses(128, 2);
    wr(8'h00, 32'h1800);
    pins(4'b0000);
    wr(8'h44, 32'h20);
    repeat (3) @(posedge ref_clk_i);
    chk_pin("clock select", 4'b0010, {2'b00, slow, refen});
    rd(8'h80, q, e);
    chk_reg("lowest power flag", 32'h80, q & 32'h80);
    mgmt_u.exit_slow_osc();
    repeat (3) @(posedge ref_clk_i);
    chk_pin("clock select", 4'b0001, {2'b00, slow, refen});
    chk_reg("soft reset pulses", 32'h1, n_srst);
    pins(4'b1111);
    rd(8'h60, q, e);
    chk_reg("defaults after soft reset", 32'h800, q);
    // Energy-detect power-down with the PLL left running, then disabled again
    wr(8'h60, 32'h0);
    pins(4'b0111);
    wr(8'h60, 32'h800);
    pins(4'b1111);
    wrap_up();
  end
endmodule // test_phy_power_mode_control
